//--- common/ppm_pkg.sv
// constants, register map and helpers of the port pin multiplexer
// Function
// - port 0 bits 0 and 7 are inputs only, bits 1 to 6 bidirectional
// - ports 0-3, 5-7, 12, 13 set each pin direction by its own bit
// - ports 0-7 pull-up only on input pins enabled in low option reg
// - ports 12 and 13 input pull-ups come from the high option reg
// - port 1 pin used as analog input always has its pull-up off
// - port 4 direction is one bit for all eight pins, in mode reg
// - any falling edge on a port 4 pin sets the test flag
// - expansion mode: port 4 is low address/data bus, no pull-ups
// - expansion mode: port 5 drives high address byte, no pull-ups
// - expansion mode: port 6 bits 4-7 are read, write, wait, latch
// - port 6 bits 0-3 open drain; pull-ups only bits 4-7 as inputs
// - expansion without wait leaves port 6 bit 6 a normal port pin
// - each interrupt input detects rising, falling or both edges
// - a valid edge on interrupt input 0 or 1 is a capture trigger
// - port 0 bit 1 gives capture trigger, bit 0 timer count clock
// - port 12 in control mode shows real-time data taken on trigger
// - port or control mode is chosen per pin, except on port 4
// - the system reset is active low and resets the block
`default_nettype none
package ppm_pkg;
  // ************************************************************
  // sizes and port slots
  // ************************************************************
  localparam int NPORT = 10;
  localparam int PW    = 8;
  localparam int AW    = 6;
  localparam int IDX_W = 4;
  localparam int NINTP = 7;
  localparam int P0 = 0, P1 = 1, P2 = 2, P3 = 3, P4 = 4, P5 = 5;
  localparam int P6 = 6, P7 = 7, P12 = 8, P13 = 9;
  localparam logic [PW-1:0] PORT_MASK [NPORT] = '{8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'h03};

  // ************************************************************
  // register offsets and fields
  // ************************************************************
  localparam logic [AW-1:0] OFF_LATCH = 6'h00; // plus port slot
  localparam logic [AW-1:0] OFF_DIR   = 6'h10; // plus port slot
  localparam logic [AW-1:0] OFF_CTL   = 6'h20; // plus port slot
  localparam logic [AW-1:0] OFF_PULLUP_OPTION_LOW_REGISTER  = 6'h30;
  localparam logic [AW-1:0] OFF_PULLUP_OPTION_HIGH_REGISTER  = 6'h31;
  localparam logic [AW-1:0] OFF_MM    = 6'h32;
  localparam logic [AW-1:0] OFF_FLAG  = 6'h33;
  localparam logic [AW-1:0] OFF_RISE  = 6'h34;
  localparam logic [AW-1:0] OFF_FALL  = 6'h35;
  localparam int MM_P4_IN = 0, MM_EXP = 1, MM_WAIT = 2;
  localparam int PULLUP_OPTION_HIGH_REGISTER_P12 = 0, PULLUP_OPTION_HIGH_REGISTER_P13 = 1;
  localparam int FLAG_BIT = 0;
  localparam int TI_CLK_BIT = 0, TI_CAP_BIT = 1;
  localparam int P6_RD = 4, P6_WR = 5, P6_WAIT = 6, P6_ADDRESS_LATCH_STROBE = 7;
  localparam logic [PW-1:0]    P0_IN_ONLY    = 8'h81;
  localparam logic [PW-1:0]    P6_OD_MASK    = 8'h0F;
  localparam logic [NINTP-1:0] INTP_CAP_MASK = 7'h03;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PW-1:0] DIR_RST   = 8'hFF;
  localparam logic [PW-1:0] MM_RST    = 8'h01;
  localparam logic [PW-1:0] P4_PREV_R = 8'hFF;

  // per-port register window: upper bits hit base, slot in range
  function automatic logic port_reg(input logic [AW-1:0] a,
                                    input logic [AW-1:0] base);
    return (a[AW-1:IDX_W] == base[AW-1:IDX_W]) &&
           (a[IDX_W-1:0] < IDX_W'(NPORT));
  endfunction : port_reg

  // direction bits that software may change in one port
  function automatic logic [PW-1:0] dir_wmask(input logic [IDX_W-1:0] i);
    return PORT_MASK[i] & ((i == IDX_W'(P0)) ? ~P0_IN_ONLY : '1);
  endfunction : dir_wmask
endpackage : ppm_pkg
`default_nettype wire

//--- common/ppm_edge_if.sv
// edge detector request group between the multiplexer and its detector
`default_nettype none
interface ppm_edge_if #(parameter int N = 7);
  logic [N-1:0] sample;
  logic [N-1:0] rise_en;
  logic [N-1:0] fall_en;
  logic [N-1:0] hit;
  modport det (input sample, input rise_en, input fall_en, output hit);
  modport src (output sample, output rise_en, output fall_en, input hit);
endinterface : ppm_edge_if
`default_nettype wire

//--- design/ppm_edge_det.sv
// edge detector for the external interrupt request inputs
`default_nettype none
module ppm_edge_det
  import ppm_pkg::*;
#(
  parameter int N = NINTP
) (
  // clock, reset and enable
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // edge request group
  ppm_edge_if.det   e
);
  logic [N-1:0] prev_q;
  logic [N-1:0] hit_d;

  // rising, falling or both, chosen per input by the two enables
  assign hit_d = (e.rise_en & ~prev_q & e.sample) |
                 (e.fall_en & prev_q & ~e.sample);

  // hit is a one-cycle pulse while ce stays high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
      e.hit  <= '0;
    end else if (ce) begin
      prev_q <= e.sample;
      e.hit  <= hit_d;
    end
  end
endmodule : ppm_edge_det
`default_nettype wire

//--- design/ppm_top.sv
// pin multiplexer for all ports: registers, drive, pull-ups and edges
//
// Design decisions made here: the placing of the registers and the strobed register port.
`default_nettype none
module ppm_top
  import ppm_pkg::*;
(
  // clock, reset and enable
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // register port
  input  wire logic [AW-1:0]            reg_addr,
  input  wire logic [PW-1:0]            reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [PW-1:0]            reg_rdata,
  // pins
  input  wire logic [NPORT-1:0][PW-1:0] pin_in,
  output logic      [NPORT-1:0][PW-1:0] pin_out,
  output logic      [NPORT-1:0][PW-1:0] pin_oe,
  output logic      [NPORT-1:0][PW-1:0] pin_pu,
  // alternate functions of serial, timer and clock blocks
  input  wire logic [NPORT-1:0][PW-1:0] alt_out,
  input  wire logic [NPORT-1:0][PW-1:0] alt_oe,
  // real-time output source
  input  wire logic [PW-1:0]            rt_data,
  input  wire logic                     rt_trigger,
  // external memory bus
  input  wire logic [2*PW-1:0]          exp_addr,
  input  wire logic [PW-1:0]            exp_ad_out,
  input  wire logic                     exp_ad_oe,
  input  wire logic                     exp_rd_n,
  input  wire logic                     exp_wr_n,
  input  wire logic                     address_latch_strobe,
  output logic      [PW-1:0]            low_addr_data_bus_in,
  output logic                          exp_wait_n,
  // interrupt and timer inputs
  output logic      [NINTP-1:0]         intp_req,
  output logic                          timer16_capture_pulse,
  output logic                          timer16_count_clock_input,
  output logic                          capture_trigger_input,
  output logic                          falling_edge_test_flag
);
  // ************************************************************
  // state and decode
  // ************************************************************
  logic [NPORT-1:0][PW-1:0] latch_q;
  logic [NPORT-1:0][PW-1:0] dir_q;
  logic [NPORT-1:0][PW-1:0] ctl_q;
  logic [NPORT-1:0][PW-1:0] out_d;
  logic [NPORT-1:0][PW-1:0] oe_d;
  logic [NPORT-1:0][PW-1:0] pu_d;
  logic [NPORT-1:0][PW-1:0] view;
  logic [PW-1:0]            pullup_option_low_register_q;
  logic [PW-1:0]            pullup_option_high_register_q;
  logic [PW-1:0]            mm_q;
  logic [PW-1:0]            rise_q;
  logic [PW-1:0]            fall_q;
  logic [PW-1:0]            rt_q;
  logic [PW-1:0]            p4_prev_q;
  logic [PW-1:0]            rd_mux;
  logic [PW-1:0]            p6_ctl_val;
  logic [PW-1:0]            rdata_q;
  logic [IDX_W-1:0]         idx;
  logic                     flag_q;
  logic                     exp_mode;
  logic                     wait_en;
  logic                     p4_fall;
  logic                     wr_latch;
  logic                     wr_dir;
  logic                     wr_ctl;
  logic                     wr_flag;

  ppm_edge_if #(.N(NINTP)) eif ();

  // write strobes for the latch, direction, control and flag registers
  assign idx      = reg_addr[IDX_W-1:0];
  assign wr_latch = reg_wr && port_reg(reg_addr, OFF_LATCH);
  assign wr_dir   = reg_wr && port_reg(reg_addr, OFF_DIR);
  assign wr_ctl   = reg_wr && port_reg(reg_addr, OFF_CTL);
  assign wr_flag  = reg_wr && (reg_addr == OFF_FLAG);
  assign exp_mode = mm_q[MM_EXP];
  assign wait_en  = mm_q[MM_WAIT];
  assign p4_fall  = |(p4_prev_q & ~pin_in[P4]);

  // bus strobes on port 6 bits 4 to 7; bit 6 is the wait input
  assign p6_ctl_val = {address_latch_strobe, 1'b0, exp_wr_n, exp_rd_n,
                       4'h0};

  // read mux; unmapped addresses read as zero
  assign rd_mux =
    port_reg(reg_addr, OFF_LATCH) ? view[idx]  :
    port_reg(reg_addr, OFF_DIR)   ? dir_q[idx] :
    port_reg(reg_addr, OFF_CTL)   ? ctl_q[idx] :
    (reg_addr == OFF_PULLUP_OPTION_LOW_REGISTER)        ? pullup_option_low_register_q     :
    (reg_addr == OFF_PULLUP_OPTION_HIGH_REGISTER)        ? pullup_option_high_register_q     :
    (reg_addr == OFF_MM)          ? mm_q       :
    (reg_addr == OFF_FLAG)        ? PW'(flag_q) :
    (reg_addr == OFF_RISE)        ? rise_q     :
    (reg_addr == OFF_FALL)        ? fall_q     : '0;

  // ************************************************************
  // software registers
  // ************************************************************
  // per-port latch, direction and mode; bits beyond a port stay reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= '0;
      dir_q   <= {NPORT{DIR_RST}};
      ctl_q   <= '0;
    end else if (ce) begin
      if (wr_latch)
        latch_q[idx] <= reg_wdata & PORT_MASK[idx];
      if (wr_dir)
        dir_q[idx] <= (reg_wdata & dir_wmask(idx)) |
                      (DIR_RST & ~dir_wmask(idx));
      if (wr_ctl)
        ctl_q[idx] <= reg_wdata & PORT_MASK[idx];
    end
  end

  // option, mode and edge select registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_option_low_register_q <= '0;
      pullup_option_high_register_q <= '0;
      mm_q   <= MM_RST;
      rise_q <= '0;
      fall_q <= '0;
    end else if (ce && reg_wr) begin
      if (reg_addr == OFF_PULLUP_OPTION_LOW_REGISTER) pullup_option_low_register_q <= reg_wdata;
      if (reg_addr == OFF_PULLUP_OPTION_HIGH_REGISTER) pullup_option_high_register_q <= reg_wdata;
      if (reg_addr == OFF_MM)   mm_q   <= reg_wdata;
      if (reg_addr == OFF_RISE) rise_q <= reg_wdata;
      if (reg_addr == OFF_FALL) fall_q <= reg_wdata;
    end
  end

  // test flag: an edge in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q    <= 1'b0;
      p4_prev_q <= P4_PREV_R;
    end else if (ce) begin
      p4_prev_q <= pin_in[P4];
      flag_q    <= p4_fall ||
                   (flag_q && !(wr_flag && !reg_wdata[FLAG_BIT]));
    end
  end

  // real-time data only moves on the trigger, not on writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rt_q <= '0;
    else if (ce && rt_trigger)
      rt_q <= rt_data;
  end

  // ************************************************************
  // per-pin drive, value and pull-up
  // ************************************************************
  for (genvar k = 0; k < NPORT; k++) begin : g_port
    for (genvar b = 0; b < PW; b++) begin : g_bit
      localparam bit PRESENT = PORT_MASK[k][b];
      localparam bit LIVE = PRESENT && !(k == P0 && P0_IN_ONLY[b]);
      localparam bit ANA  = (k == P1) || (k == P13);
      localparam bit CIN  = ANA || (k == P0);
      localparam bit OD   = (k == P6) && P6_OD_MASK[b];
      localparam bit WPIN = (k == P6) && (b == P6_WAIT);
      localparam bit EXPB = (k == P4) || (k == P5) ||
                            ((k == P6) && (b >= P6_RD));
      localparam int PUI  = (k <= P7) ? k :
                            ((k == P12) ? PULLUP_OPTION_HIGH_REGISTER_P12 : PULLUP_OPTION_HIGH_REGISTER_P13);
      logic exp_on;
      logic ctl_on;
      logic pu_en;
      logic drv;
      logic val;

      // bus roles take the pin; bit 6 only when wait is in use
      assign exp_on = exp_mode && EXPB && (wait_en || !WPIN);
      // port 4 has no per-pin control mode
      assign ctl_on = ctl_q[k][b] && !exp_on && (k != P4);
      // low option reg for ports 0 to 7, high one for 12 and 13
      assign pu_en  = (k <= P7) ? pullup_option_low_register_q[PUI] : pullup_option_high_register_q[PUI];

      // input-only bits never drive; control inputs stay released
      assign drv = !LIVE  ? 1'b0 :
        exp_on ? ((k == P4) ? exp_ad_oe : !WPIN) :
        ctl_on ? (CIN ? 1'b0 : ((k == P12) ? 1'b1 : alt_oe[k][b])) :
        ((k == P4) ? !mm_q[MM_P4_IN] : !dir_q[k][b]);

      assign val = exp_on ?
        ((k == P4) ? exp_ad_out[b] :
         (k == P5) ? exp_addr[PW+b] : p6_ctl_val[b]) :
        ctl_on ? ((k == P12) ? rt_q[b] : alt_out[k][b]) :
        latch_q[k][b];

      // open-drain bits only pull low
      assign out_d[k][b] = OD ? 1'b0 : val;
      assign oe_d[k][b]  = drv && !(OD && val);
      // bus roles, analog use and open drain force pull-up off
      assign pu_d[k][b]  = PRESENT && !drv && pu_en && !OD &&
                           !exp_on && !(ctl_on && ANA);
      // reads see the latch on driven pins, the pin otherwise
      assign view[k][b]  = drv ? latch_q[k][b] : pin_in[k][b];
    end
  end

  // ************************************************************
  // interrupt edges and timer inputs
  // ************************************************************
  assign eif.sample  = pin_in[P0][NINTP-1:0];
  assign eif.rise_en = rise_q[NINTP-1:0] & ctl_q[P0][NINTP-1:0];
  assign eif.fall_en = fall_q[NINTP-1:0] & ctl_q[P0][NINTP-1:0];

  ppm_edge_det #(.N(NINTP)) ppm_edge_det_i (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .e       (eif.det)
  );

  assign intp_req              = eif.hit;
  assign timer16_capture_pulse = |(eif.hit & INTP_CAP_MASK);
  assign falling_edge_test_flag = flag_q;
  assign reg_rdata             = rdata_q;

  // ************************************************************
  // registered outputs
  // ************************************************************
  // pins and timer levels are retimed so every output but timer16_capture_pulse is a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out                   <= '0;
      pin_oe                    <= '0;
      pin_pu                    <= '0;
      rdata_q                   <= '0;
      low_addr_data_bus_in      <= '0;
      exp_wait_n                <= 1'b1;
      timer16_count_clock_input <= 1'b0;
      capture_trigger_input     <= 1'b0;
    end else if (ce) begin
      pin_out              <= out_d;
      pin_oe               <= oe_d;
      pin_pu               <= pu_d;
      rdata_q              <= reg_rd ? rd_mux : '0;
      low_addr_data_bus_in <= pin_in[P4];
      exp_wait_n           <= pin_in[P6][P6_WAIT] || !wait_en;
      timer16_count_clock_input <=
        pin_in[P0][TI_CLK_BIT] && ctl_q[P0][TI_CLK_BIT];
      capture_trigger_input <=
        pin_in[P0][TI_CAP_BIT] && ctl_q[P0][TI_CAP_BIT];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_p0_in_only;
    (pin_oe[P0] & P0_IN_ONLY) == '0;
  endproperty
  a_p0_in_only: assert property (p_p0_in_only)
    else $error("port 0 input-only bit driven");

  property p_dir_write;
    ce && reg_wr && reg_addr == AW'(OFF_DIR + AW'(P2))
      |=> dir_q[P2] == $past(reg_wdata);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("port 2 direction write lost");

  property p_pu_input_only;
    (pin_pu & pin_oe) == '0;
  endproperty
  a_pu_input_only: assert property (p_pu_input_only)
    else $error("pull-up on a driven pin");

  property p_pullup_option_high_register;
    ce && pullup_option_high_register_q[PULLUP_OPTION_HIGH_REGISTER_P12] && dir_q[P12] == '1 && ctl_q[P12] == '0
      |=> pin_pu[P12] == '1;
  endproperty
  a_pullup_option_high_register: assert property (p_pullup_option_high_register)
    else $error("port 12 pull-up not from high option");

  property p_analog_pu;
    ce |=> (pin_pu[P1] & $past(ctl_q[P1])) == '0;
  endproperty
  a_analog_pu: assert property (p_analog_pu)
    else $error("pull-up on analog input");

  property p_p4_dir;
    ce && !exp_mode |=> pin_oe[P4] == {PW{!$past(mm_q[MM_P4_IN])}};
  endproperty
  a_p4_dir: assert property (p_p4_dir)
    else $error("port 4 direction not common");

  property p_flag_set;
    ce && p4_fall |=> falling_edge_test_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("falling edge missed on port 4");

  property p_exp_p4_p5;
    ce && exp_mode |=> pin_pu[P4] == '0 && pin_pu[P5] == '0 &&
      pin_out[P4] == $past(exp_ad_out) &&
      pin_out[P5] == $past(exp_addr[2*PW-1:PW]) && pin_oe[P5] == '1;
  endproperty
  a_exp_p4_p5: assert property (p_exp_p4_p5)
    else $error("expansion bus pins wrong");

  property p_exp_p6;
    ce && exp_mode && wait_en |=> !pin_oe[P6][P6_WAIT] &&
      pin_out[P6][P6_ADDRESS_LATCH_STROBE] == $past(address_latch_strobe) &&
      pin_out[P6][P6_RD] == $past(exp_rd_n) &&
      pin_pu[P6][PW-1:P6_RD] == '0;
  endproperty
  a_exp_p6: assert property (p_exp_p6)
    else $error("port 6 strobes wrong");

  property p_open_drain;
    (pin_out[P6] & P6_OD_MASK) == '0 && (pin_pu[P6] & P6_OD_MASK) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain bit driven high or pulled up");

  property p_no_wait_port;
    ce && exp_mode && !wait_en && !ctl_q[P6][P6_WAIT] |=>
      pin_out[P6][P6_WAIT] == $past(latch_q[P6][P6_WAIT]);
  endproperty
  a_no_wait_port: assert property (p_no_wait_port)
    else $error("bit 6 not a port pin without wait");

  property p_rise_capture;
    ce && $past(ce) && rise_q[0] && ctl_q[P0][0] &&
      !$past(pin_in[P0][0]) && pin_in[P0][0]
      |=> intp_req[0] && timer16_capture_pulse;
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("interrupt 0 edge lost");

  sequence s_rt_take;
    ce && rt_trigger && ctl_q[P12] == '1 && !reg_wr;
  endsequence
  sequence s_rt_pass;
    ce && ctl_q[P12] == '1;
  endsequence
  property p_rt_out;
    s_rt_take ##1 s_rt_pass |=> pin_out[P12] == $past(rt_data, 2);
  endproperty
  a_rt_out: assert property (p_rt_out)
    else $error("real-time data not shown");

  property p_reset_state;
    !$past(rst_n) |-> dir_q == {NPORT{DIR_RST}} && ctl_q == '0 &&
      pin_pu == '0 && pin_oe == '0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset wrong");
endmodule : ppm_top
`default_nettype wire

//--- tb/ppm_board_model.sv
// board side of every pin: resolves device drive, sources and pull-ups
`default_nettype none
module ppm_board_model
  import ppm_pkg::*;
(
  // clock
  input  wire logic                     sys_clk,
  // device side
  input  wire logic [NPORT-1:0][PW-1:0] pin_out,
  input  wire logic [NPORT-1:0][PW-1:0] pin_oe,
  input  wire logic [NPORT-1:0][PW-1:0] pin_pu,
  // board sources
  input  wire logic [NPORT-1:0][PW-1:0] ext_val,
  input  wire logic [NPORT-1:0][PW-1:0] ext_en,
  // resolved levels
  output logic      [NPORT-1:0][PW-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [PW-1:0] float_q = 8'h55;
  // open lines wander each cycle, so a stale level never passes
  always_ff @(posedge sys_clk) float_q <= ~float_q;
  // device drive wins, then the board source, then the pull-up
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      pin_in[p] = (pin_oe[p] & pin_out[p])
                | (~pin_oe[p] & ext_en[p] & ext_val[p])
                | (~pin_oe[p] & ~ext_en[p] & (pin_pu[p] | float_q));
    end
  end
endmodule : ppm_board_model
`default_nettype wire

//--- tb/ppm_top_bench.sv
// self-checking bench of the port pin multiplexer
`default_nettype none
module ppm_top_bench
  import ppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, ce, reg_wr, reg_rd, rt_trigger;
  logic exp_ad_oe, exp_rd_n, exp_wr_n, ale, cap, tclk, ctrig, wait_n, flag;
  logic [AW-1:0] reg_addr;
  logic [PW-1:0] reg_wdata, reg_rdata, rt_data, exp_ad_out, ad_in;
  logic [2*PW-1:0] exp_addr;
  logic [NPORT-1:0][PW-1:0] pin_in, pin_out, pin_oe, pin_pu;
  logic [NPORT-1:0][PW-1:0] alt_out, alt_oe, ext_val, ext_en;
  logic [NINTP-1:0] intp_req;
  int mismatches, compares;

  ppm_top ppm_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
    .alt_out(alt_out), .alt_oe(alt_oe), .rt_data(rt_data),
    .rt_trigger(rt_trigger), .exp_addr(exp_addr), .exp_ad_out(exp_ad_out),
    .exp_ad_oe(exp_ad_oe), .exp_rd_n(exp_rd_n), .exp_wr_n(exp_wr_n),
    .address_latch_strobe(ale), .low_addr_data_bus_in(ad_in),
    .exp_wait_n(wait_n), .intp_req(intp_req),
    .timer16_capture_pulse(cap), .timer16_count_clock_input(tclk),
    .capture_trigger_input(ctrig), .falling_edge_test_flag(flag));
  ppm_board_model ppm_board_model_i (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pu(pin_pu), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));

  // ************************************************************
  // common tasks
  // ************************************************************
  task automatic stop_test;
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] a, input logic [PW-1:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, then drop to 0
  task automatic rd(input logic [AW-1:0] a, input logic [7:0] e,
                    input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 chk(nm, e, reg_rdata);
    @(posedge sys_clk);
    #1 chk(nm, 8'h00, reg_rdata);
  endtask : rd
  // pins are retimed, so let register effects reach them
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  // one level change on port 0, pulses counted over a fixed span
  task automatic edge_try(input int b, input logic v, input logic e);
    logic [7:0] n, c;
    n = 8'h00;
    c = 8'h00;
    @(posedge sys_clk);
    ext_val[P0][b] <= v;
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      n = n + {7'h00, intp_req[b]};
      c = c + {7'h00, cap};
    end
    chk("intp", {7'h00, e}, n);
    chk("cap", {7'h00, e & (b < 2)}, c);
  endtask : edge_try

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_pull;
    wr(6'h10, 8'h00);
    wr(6'h30, 8'hFF);
    wr(6'h12, 8'h0F);
    wr(6'h31, 8'h01);
    wr(6'h21, 8'h0F);
    wr(6'h19, 8'hFE);
    settle;
    rd(6'h10, 8'h81, "dir0");
    chk("oe0", 8'h7E, pin_oe[P0]);
    chk("pu0", 8'h81, pin_pu[P0]);
    chk("oe2", 8'hF0, pin_oe[P2]);
    chk("pu2", 8'h0F, pin_pu[P2]);
    chk("pu12", 8'hFF, pin_pu[P12]);
    chk("pu13", 8'h00, pin_pu[P13]);
    chk("pu1", 8'hF0, pin_pu[P1]);
    chk("oe13", 8'h01, pin_oe[P13]);
    chk("out13", 8'h00, pin_out[P13]);
  endtask : t_pull
  task automatic t_edge;
    wr(6'h10, 8'hFF);
    wr(6'h20, 8'h07);
    wr(6'h34, 8'h03);
    wr(6'h35, 8'h05);
    settle;
    chk("tclk", 8'h00, {7'h00, tclk});
    edge_try(1, 1'b1, 1'b1);
    chk("trig", 8'h01, {7'h00, ctrig});
    edge_try(1, 1'b0, 1'b0);
    edge_try(0, 1'b1, 1'b1);
    chk("tclk", 8'h01, {7'h00, tclk});
    edge_try(0, 1'b0, 1'b1);
    edge_try(2, 1'b1, 1'b0);
    edge_try(2, 1'b0, 1'b1);
  endtask : t_edge
  task automatic t_flag;
    @(posedge sys_clk);
    ext_val[P4][5] <= 1'b0;
    settle;
    chk("flag", 8'h01, {7'h00, flag});
    rd(6'h33, 8'h01, "flagrd");
    wr(6'h33, 8'h00);
    ext_val[P4] <= 8'hFF;
    settle;
    chk("flag", 8'h00, {7'h00, flag});
  endtask : t_flag
  task automatic t_rt;
    wr(6'h18, 8'h00);
    wr(6'h28, 8'hFF);
    rt_data    <= 8'hA5;
    rt_trigger <= 1'b1;
    @(posedge sys_clk);
    rt_data    <= 8'h3C;
    rt_trigger <= 1'b0;
    settle;
    chk("rt", 8'hA5, pin_out[P12]);
  endtask : t_rt
  // serial pin prepared in port mode first, then handed to the peripheral
  task automatic t_serial;
    wr(6'h07, 8'h02);
    wr(6'h17, 8'h05);
    alt_oe[P7] <= 8'h02;
    settle;
    chk("out7", 8'h02, pin_out[P7]);
    rd(6'h17, 8'hFD, "dir7");
    wr(6'h27, 8'h07);
    settle;
    chk("oe7", 8'h02, pin_oe[P7]);
    chk("out7c", 8'h00, pin_out[P7]);
    chk("pu7", 8'h05, pin_pu[P7]);
  endtask : t_serial
  task automatic t_exp;
    @(posedge sys_clk);
    exp_addr   <= 16'h5A00;
    exp_ad_out <= 8'h3C;
    exp_ad_oe  <= 1'b1;
    exp_rd_n   <= 1'b0;
    ale        <= 1'b1;
    wr(6'h32, 8'h03);
    settle;
    chk("ad", 8'h3C, pin_out[P4]);
    chk("adin", 8'h3C, ad_in);
    chk("pu4", 8'h00, pin_pu[P4]);
    chk("hi", 8'h5A, pin_out[P5]);
    chk("oe5", 8'hFF, pin_oe[P5]);
    chk("pu5", 8'h00, pin_pu[P5]);
    chk("ctl6", 8'hA0, pin_out[P6] & 8'hB0);
    chk("oe6", 8'hB0, pin_oe[P6] & 8'hF0);
    chk("pu6", 8'h40, pin_pu[P6]);
    chk("wait", 8'h01, {7'h00, wait_n});
    wr(6'h32, 8'h07);
    ext_val[P6][P6_WAIT] <= 1'b0;
    settle;
    chk("pu6w", 8'h00, pin_pu[P6]);
    chk("oe6w", 8'hB0, pin_oe[P6] & 8'hF0);
    chk("waitw", 8'h00, {7'h00, wait_n});
  endtask : t_exp

  // ************************************************************
  // clock, reset and main sequence
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // cut a hang short through the same closing report
  initial begin
    #1ms;
    mismatches++;
    stop_test();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, rt_trigger, exp_ad_oe, ale} = '0;
    {ce, exp_rd_n, exp_wr_n} = 3'b111;
    {reg_addr, reg_wdata, rt_data, exp_ad_out, exp_addr} = '0;
    {alt_out, alt_oe} = '0;
    ext_val = '1;
    ext_val[P0] = 8'h00;
    ext_en = '1;
    ext_en[P3] = 8'h00;
    mismatches = 0;
    compares = 0;
    repeat (7) @(posedge sys_clk);
    #1;
    for (int p = 0; p < NPORT; p++) begin
      chk("rst_oe", 8'h00, pin_oe[p]);
      chk("rst_pu", 8'h00, pin_pu[p]);
    end
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(6'h12, 8'hFF, "dir2");
    rd(6'h32, 8'h01, "mode");
    rd(6'h22, 8'h00, "ctl2");
    rd(6'h30, 8'h00, "pull");
    rd(6'h3F, 8'h00, "void");
    t_pull();
    t_edge();
    t_flag();
    t_rt();
    t_serial();
    t_exp();
    stop_test();
  end
endmodule : ppm_top_bench
`default_nettype wire
